/* hdl/clamp_fault_regs.svh */
`ifndef CLAMP_FAULT_REGS_SVH
`define CLAMP_FAULT_REGS_SVH

// Alarm source bit positions in mask and state words
`define ALM_THERMAL 0
`define ALM_OVER0 1
`define ALM_OVER1 2
`define ALM_CLAMP0 3
`define ALM_CLAMP1 4
`define ALM_WIDTH 5
// Mask reset: thermal enabled, overvoltage and clamp masked
`define ALM_MASK_RST 5'h1e
// Static current limit, percent of range
`define STATIC_LIMIT_PCT 8'h8c
// Level DAC reset default codes
`define DAC_WIDTH 16
`define CLAMP_HIGH_RST 16'hffff
`define CLAMP_LOW_RST 16'h0000

`endif

/* hdl/clamp_fault_pkg.sv */
package clamp_fault_pkg;
    // Level DAC output source
    typedef enum logic [1:0] {
        LVL_GROUND,
        LVL_DEFAULT,
        LVL_PROGRAM
    } level_src_type;
    // Per-pin unit forcing mode
    typedef enum logic {
        MODE_FORCE_VOLTAGE,
        MODE_FORCE_CURRENT
    } force_mode_type;
endpackage : clamp_fault_pkg

/* hdl/clamp_channel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "clamp_fault_regs.svh"

// Per-channel clamp alarm qualification, one cycle registered
module clamp_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Channel status, already synchronised
    input wire logic forceCurrent,
    input wire logic clampEnableBit,
    input wire logic highOutOfRange,
    input wire logic lowOutOfRange,
    input wire logic hitHigh,
    input wire logic hitLow,
    input wire logic hitStatic,
    // Result
    output logic clampAlarm_r,
    output logic staticLimitOn_r
);
    // Voltage clamps gated by enable; current clamps always on
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clampAlarm_r <= 1'b0;
        end else if (forceCurrent) begin
            clampAlarm_r <= clampEnableBit & (hitHigh | hitLow);
        end else begin
            clampAlarm_r <= hitHigh | hitLow | hitStatic;
        end
    end

    // Static limit engaged when a level is out of range in FV
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            staticLimitOn_r <= 1'b0;
        end else begin
            staticLimitOn_r <= !forceCurrent
                && (highOutOfRange || lowOutOfRange);
        end
    end

    chk_fi_disabled: assert property (@(posedge mclk) disable iff (!arst_n)
        (forceCurrent && !clampEnableBit) |=> !clampAlarm_r)
        else $error("clamp alarm with clamps disabled");
    chk_fv_always: assert property (@(posedge mclk) disable iff (!arst_n)
        (!forceCurrent && (hitHigh || hitLow)) |=> clampAlarm_r)
        else $error("force voltage clamp hit missed");
endmodule : clamp_channel

`default_nettype wire

/* hdl/clamp_fault_alarm.sv */
`timescale 1ns/100ps
`default_nettype none
`include "clamp_fault_regs.svh"

// Summary of operation
// - In force-voltage mode current clamps stay active regardless of enable bit.
// - In force-voltage mode, out-of-range clamp levels leave a fixed 140 percent current limit.
// - Force-voltage clamp alarm on high, low or static limit hit.
// - Clamp alarm has its own mask bit.
// - Faults only set flags and drive the open-drain fault pin.
// - Under reset or no digital supply, level DACs follow remote ground.
// - Under reset or no digital supply, control bits take defaults.
// - Analog functions stay safe while reset or supply absence lasts.
// - Level DACs keep ground after release until reset sequence completes.
// - Default DAC codes load on reset, on supply loss and again after a fully clocked reset sequence.
// - Force-current clamp alarm only when clamp enable bit is set.
// - Alarm state is read-only and cleared by a read.
// - Enabled flags are ORed onto one open-drain fault pin.
// - Reset mask: thermal enabled, overvoltage and clamp masked.
module clamp_fault_alarm (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Supply and reset sequence status (asynchronous pins)
    input wire logic digitalSupplyOk,
    input wire logic resetSeqDone,
    // Channel controls, from serial interface logic on mclk
    input wire logic [1:0] forceCurrentMode,
    input wire logic [1:0] clampEnableBit,
    input wire logic [`ALM_WIDTH-1:0] maskWrData,
    input wire logic maskWrEn,
    input wire logic stateRdEn,
    input wire logic [`DAC_WIDTH-1:0] highClampLevel,
    input wire logic [`DAC_WIDTH-1:0] lowClampLevel,
    // Analog comparator status (asynchronous pins)
    input wire logic [1:0] highOutOfRange,
    input wire logic [1:0] lowOutOfRange,
    input wire logic [1:0] hitHighClamp,
    input wire logic [1:0] hitLowClamp,
    input wire logic [1:0] hitStaticLimit,
    input wire logic [1:0] overVoltage,
    input wire logic thermalFault,
    // Outputs
    output logic [`ALM_WIDTH-1:0] alarmMask_r,
    output logic [`ALM_WIDTH-1:0] alarmState_r,
    output logic [`ALM_WIDTH-1:0] stateRdData_r,
    output logic faultPinOe_r,
    output logic faultPinOut_r,
    output logic [1:0] staticLimitOn_r,
    output clamp_fault_pkg::level_src_type levelSrc_r,
    output logic [`DAC_WIDTH-1:0] highClampCode_r,
    output logic [`DAC_WIDTH-1:0] lowClampCode_r
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 15;
    logic [SW-1:0] syncA_r;
    logic [SW-1:0] syncB_r;
    logic [1:0] clampAlarm;
    logic supplyOk;
    logic seqDone;
    logic [`ALM_WIDTH-1:0] rawEvents;
    logic [`ALM_WIDTH-1:0] setNext;

    // Two stages; only syncB_r is read by logic
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {digitalSupplyOk, resetSeqDone, highOutOfRange,
                lowOutOfRange, hitHighClamp, hitLowClamp, hitStaticLimit,
                overVoltage, thermalFault};
            syncB_r <= syncA_r;
        end
    end
    assign supplyOk = syncB_r[14];
    assign seqDone = syncB_r[13];

    // ------------------------------------------------------------
    // Clamp channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        clamp_channel u_chan (
            .mclk(mclk),
            .arst_n(arst_n),
            .forceCurrent(forceCurrentMode[c]),
            .clampEnableBit(clampEnableBit[c]),
            .highOutOfRange(syncB_r[11 + c]),
            .lowOutOfRange(syncB_r[9 + c]),
            .hitHigh(syncB_r[7 + c]),
            .hitLow(syncB_r[5 + c]),
            .hitStatic(syncB_r[3 + c]),
            .clampAlarm_r(clampAlarm[c]),
            .staticLimitOn_r(staticLimitOn_r[c])
        );
    end

    // Event vector in state-register layout
    always_comb begin
        rawEvents = '0;
        rawEvents[`ALM_THERMAL] = syncB_r[0];
        rawEvents[`ALM_OVER0] = syncB_r[1];
        rawEvents[`ALM_OVER1] = syncB_r[2];
        rawEvents[`ALM_CLAMP0] = clampAlarm[0];
        rawEvents[`ALM_CLAMP1] = clampAlarm[1];
    end

    // ------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------
    // Supply loss forces defaults like the reset pin does
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarmMask_r <= `ALM_MASK_RST;
        end else if (!supplyOk) begin
            alarmMask_r <= `ALM_MASK_RST;
        end else if (maskWrEn) begin
            alarmMask_r <= maskWrData;
        end
    end

    // ------------------------------------------------------------
    // Sticky state, clear on read
    // ------------------------------------------------------------
    // A new event in the read cycle survives the clear
    assign setNext = rawEvents & ~alarmMask_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarmState_r <= '0;
            stateRdData_r <= '0;
        end else if (!supplyOk) begin
            alarmState_r <= '0;
            stateRdData_r <= '0;
        end else if (stateRdEn) begin
            stateRdData_r <= alarmState_r;
            alarmState_r <= setNext;
        end else begin
            alarmState_r <= alarmState_r | setNext;
        end
    end

    // ------------------------------------------------------------
    // Open-drain fault pin: pulled low while any enabled flag stands
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            faultPinOe_r <= 1'b0;
            faultPinOut_r <= 1'b0;
        end else begin
            faultPinOe_r <= |(alarmState_r & ~alarmMask_r);
            faultPinOut_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Level DAC source and codes
    // ------------------------------------------------------------
    // Ground until a full reset sequence; programmed codes only after
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            levelSrc_r <= clamp_fault_pkg::LVL_GROUND;
            highClampCode_r <= `CLAMP_HIGH_RST;
            lowClampCode_r <= `CLAMP_LOW_RST;
        end else if (!supplyOk) begin
            levelSrc_r <= clamp_fault_pkg::LVL_GROUND;
            highClampCode_r <= `CLAMP_HIGH_RST;
            lowClampCode_r <= `CLAMP_LOW_RST;
        end else begin
            case (levelSrc_r)
                clamp_fault_pkg::LVL_GROUND: begin
                    if (seqDone) begin
                        levelSrc_r <= clamp_fault_pkg::LVL_DEFAULT;
                    end
                end
                clamp_fault_pkg::LVL_DEFAULT: begin
                    highClampCode_r <= `CLAMP_HIGH_RST;
                    lowClampCode_r <= `CLAMP_LOW_RST;
                    levelSrc_r <= clamp_fault_pkg::LVL_PROGRAM;
                end
                clamp_fault_pkg::LVL_PROGRAM: begin
                    highClampCode_r <= highClampLevel;
                    lowClampCode_r <= lowClampLevel;
                end
                default: begin
                    levelSrc_r <= clamp_fault_pkg::LVL_GROUND;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ground_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (levelSrc_r == clamp_fault_pkg::LVL_GROUND && !seqDone)
        |=> levelSrc_r == clamp_fault_pkg::LVL_GROUND)
        else $error("level left ground before sequence");
    chk_supply_loss: assert property (@(posedge mclk) disable iff (!arst_n)
        !supplyOk |=> (levelSrc_r == clamp_fault_pkg::LVL_GROUND
        && alarmMask_r == `ALM_MASK_RST))
        else $error("defaults not forced on supply loss");
    chk_read_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        (stateRdEn && supplyOk) |=> alarmState_r == $past(setNext))
        else $error("state not cleared by read");
    chk_sticky_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (alarmState_r != '0 && !stateRdEn && supplyOk)
        |=> (alarmState_r & $past(alarmState_r)) == $past(alarmState_r))
        else $error("flag dropped without read");
    chk_mask_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        ((alarmState_r & ~alarmMask_r) == '0) |=> !faultPinOe_r)
        else $error("masked flag drove fault pin");
    chk_fault_pin: assert property (@(posedge mclk) disable iff (!arst_n)
        ((alarmState_r & ~alarmMask_r) != '0) |=> faultPinOe_r)
        else $error("fault pin missed enabled flag");
    chk_mask_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (maskWrEn && supplyOk) |=> alarmMask_r == $past(maskWrData))
        else $error("mask write lost");
    chk_default_step: assert property (@(posedge mclk) disable iff (!arst_n)
        (levelSrc_r == clamp_fault_pkg::LVL_GROUND && seqDone && supplyOk)
        |=> levelSrc_r == clamp_fault_pkg::LVL_DEFAULT)
        else $error("defaults not loaded after sequence");
endmodule : clamp_fault_alarm

`default_nettype wire

/* tb/seq_controller.sv */
`timescale 1ns/100ps
`default_nettype none

// Supervising controller: clocks the serial reset sequence on request
module seq_controller (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request from the bench, lag sets a prompt or slow answer
    input wire logic seqStart,
    input wire logic [3:0] seqLag,
    // Completion towards the device
    output logic resetSeqDone
);
    logic [4:0] cnt_r;

    // Sequence runs only after reset release, then one done pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 5'h00;
            resetSeqDone <= 1'b0;
        end else begin
            resetSeqDone <= (cnt_r == 5'h01);
            if (seqStart) cnt_r <= {1'b0, seqLag} + 5'h01;
            else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule : seq_controller

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic supplyOk = 1'b0, seqStart = 1'b0, seqDone;
    logic maskWrEn = 1'b0, stateRdEn = 1'b0, thermal = 1'b0;
    logic [3:0] seqLag = 4'h0;
    logic [1:0] fcMode = 2'h0, clEn = 2'h0, hiOor = 2'h0, loOor = 2'h0;
    logic [1:0] hitH = 2'h0, hitL = 2'h0, hitS = 2'h0, ovr = 2'h0;
    logic [4:0] maskWd = 5'h00, mask, state, rdData;
    logic [15:0] hiLvl = 16'h0000, loLvl = 16'h0000, hiCode, loCode;
    logic oe, odOut;
    logic [1:0] staticOn;
    logic [9:0] r;
    logic [1:0] expC;
    clamp_fault_pkg::level_src_type lvl;
    integer seed = 7556;
    integer bad_count = 0, cmp_count = 0, i;

    // Free-running 250 MHz clock
    always #2 mclk = ~mclk;

    clamp_fault_alarm clamp_fault_alarm_inst (
        .mclk(mclk), .arst_n(arst_n), .digitalSupplyOk(supplyOk),
        .resetSeqDone(seqDone), .forceCurrentMode(fcMode),
        .clampEnableBit(clEn), .maskWrData(maskWd), .maskWrEn(maskWrEn),
        .stateRdEn(stateRdEn), .highClampLevel(hiLvl),
        .lowClampLevel(loLvl), .highOutOfRange(hiOor),
        .lowOutOfRange(loOor), .hitHighClamp(hitH), .hitLowClamp(hitL),
        .hitStaticLimit(hitS), .overVoltage(ovr), .thermalFault(thermal),
        .alarmMask_r(mask), .alarmState_r(state), .stateRdData_r(rdData),
        .faultPinOe_r(oe), .faultPinOut_r(odOut),
        .staticLimitOn_r(staticOn), .levelSrc_r(lvl),
        .highClampCode_r(hiCode), .lowClampCode_r(loCode)
    );

    seq_controller seq_controller_inst (
        .mclk(mclk), .arst_n(arst_n), .seqStart(seqStart),
        .seqLag(seqLag), .resetSeqDone(seqDone)
    );

    // Inputs always move 1 ns after the rising edge
    task automatic tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read strobe; captured data is looked at once it has landed
    task automatic rd;
        stateRdEn = 1'b1;
        tick(1);
        stateRdEn = 1'b0;
        tick(1);
    endtask : rd

    // Expected clamp alarm of one channel
    function automatic logic clampExp(input logic fc, en, h, l, s);
        return fc ? (en & (h | l)) : (h | l | s);
    endfunction : clampExp

    task automatic wrap_up;
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Hang guard, far beyond the few hundred cycles of the run
    initial begin
        #8000;
        bad_count++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        tick(1);
        supplyOk = 1'b1; // Supply ramps while reset is held
        tick(2);
        chk(mask, 5'h1e);
        chk(lvl, clamp_fault_pkg::LVL_GROUND);
        chk(hiCode, 16'hffff);
        chk(loCode, 16'h0000);
        chk(oe, 1'b0);
        arst_n = 1'b1;
        hiLvl = 16'($random(seed));
        loLvl = 16'($random(seed));
        tick(10);
        chk(lvl, clamp_fault_pkg::LVL_GROUND);
        chk(hiCode, 16'hffff);
        seqLag = 4'($random(seed));
        seqStart = 1'b1;
        tick(1);
        seqStart = 1'b0;
        tick(30);
        chk(lvl, clamp_fault_pkg::LVL_PROGRAM);
        chk(hiCode, hiLvl);
        chk(loCode, loLvl);
        // Unmasked thermal pulse: sticky flag, pin, then clear on read
        thermal = 1'b1;
        tick(1);
        thermal = 1'b0;
        tick(6);
        chk(state, 5'h01);
        chk({oe, odOut}, 2'h2);
        chk(lvl, clamp_fault_pkg::LVL_PROGRAM);
        rd();
        chk(rdData, 5'h01);
        chk(state, 5'h00);
        tick(2);
        chk(oe, 1'b0);
        // Clamp hit in force-voltage with enable clear, masked by default
        hitH = 2'h1;
        tick(1);
        hitH = 2'h0;
        tick(6);
        chk(state, 5'h00);
        chk(oe, 1'b0);
        maskWrEn = 1'b1;
        tick(1);
        maskWrEn = 1'b0;
        tick(3);
        chk(mask, 5'h00);
        // Same hit once unmasked: flag and pin both follow
        hitH = 2'h1;
        tick(1);
        hitH = 2'h0;
        tick(6);
        chk(state, 5'h08);
        chk(oe, 1'b1);
        rd();
        chk(rdData, 5'h08);
        ovr = 2'h2;
        tick(1);
        ovr = 2'h0;
        tick(6);
        chk(state, 5'h04);
        rd();
        // Out-of-range levels leave the static limit in force
        hiOor = 2'h1;
        loOor = 2'h2;
        tick(6);
        chk(staticOn, 2'h3);
        hiOor = 2'h0;
        loOor = 2'h0;
        tick(6);
        chk(staticOn, 2'h0);
        // Random mode, enable and hits; first trial is FI with enable clear
        for (i = 0; i < 24; i++) begin
            r = (i == 0) ? 10'h0f3 : 10'($random(seed));
            fcMode = r[1:0];
            clEn = r[3:2];
            hitH = r[5:4];
            hitL = r[7:6];
            hitS = r[9:8] & ~r[1:0];
            tick(1);
            {hitH, hitL, hitS} = 6'h00;
            tick(6);
            rd();
            expC = {clampExp(r[1], r[3], r[5], r[7], r[9] & ~r[1]),
                clampExp(r[0], r[2], r[4], r[6], r[8] & ~r[0])};
            chk(rdData[4:3], expC);
        end
        // Supply loss behaves as reset; a write meanwhile is refused
        supplyOk = 1'b0;
        tick(4);
        maskWrEn = 1'b1;
        tick(1);
        maskWrEn = 1'b0;
        tick(3);
        chk(lvl, clamp_fault_pkg::LVL_GROUND);
        chk(mask, 5'h1e);
        chk(hiCode, 16'hffff);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
